/* File: pkg/fmu_defs.svh */
/*
  Offsets, field positions, reset values and bit-time figures of the
  FSK modem framing unit. Definitions only; it is included by the package.
*/
`ifndef FMU_DEFS_SVH
`define FMU_DEFS_SVH

// Register word offsets on the plain register port
`define FMU_ADDR_W 3
`define FMU_OFS_MOD 3'h0
`define FMU_OFS_CFG 3'h1
`define FMU_OFS_EVT 3'h2
`define FMU_OFS_MASK 3'h3
`define FMU_OFS_TXB 3'h4
`define FMU_OFS_RXB 3'h5

// Modulation control fields
`define FMU_MOD_TXHI 0
`define FMU_MOD_TXEN 1
`define FMU_MOD_LVL 2
`define FMU_MOD_TXFR 3
`define FMU_MOD_RXHI 4
`define FMU_MOD_RXEN 5
`define FMU_MOD_RXFR 7

// Line format configuration fields
`define FMU_CFG_D8 0
`define FMU_CFG_ODD 1
`define FMU_CFG_PEN 2
`define FMU_CFG_STOP2 3
`define FMU_CFG_INV 6
`define FMU_CFG_BELL 7

// Event status fields
`define FMU_EV_TXRDY 0
`define FMU_EV_UDR 1
`define FMU_EV_RXRDY 2
`define FMU_EV_OVR 3
`define FMU_EV_CHG 5
`define FMU_EV_RING 6
`define FMU_EV_PAR 7

// Reset values
`define FMU_MOD_RST 8'h00
`define FMU_CFG_RST 8'h00
`define FMU_MASK_RST 8'h00

// Bit timing
`define FMU_CLK_HZ 200000000
`define FMU_BPS_HI 1200
`define FMU_BPS_BELL 150
`define FMU_BPS_V23 75
`define FMU_CNT_W 22

`endif

/* File: pkg/fmu_pkg.sv */
/*
  Types of the FSK modem framing unit: counter word, state enum and the
  packed state records of the two design modules.
  Assumes fmu_defs.svh is on the include path.
*/
`default_nettype none

package fmu_pkg;
  `include "fmu_defs.svh"

  typedef logic [`FMU_CNT_W-1:0] fmu_cnt_t;
  typedef logic [7:0] fmu_byte_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100,
    RX_SYNC = 3'b101
  } fmu_rx_e;

  typedef struct packed {
    fmu_cnt_t cnt;
    logic tick;
    logic mid;
  } fmu_cnt_s;

  typedef struct packed {
    fmu_byte_t mc;
    fmu_byte_t cfg;
    fmu_byte_t mask;
    fmu_byte_t txb;
    logic tx_full;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic tx_line;
    fmu_byte_t rxb;
    logic rx_ready;
    fmu_rx_e rx_st;
    fmu_byte_t rx_sh;
    logic [3:0] rx_n;
    logic rx_par;
    logic rx_prev;
    logic ring_prev;
    logic f_udr;
    logic f_ovr;
    logic f_chg;
    logic f_par;
    logic irq;
    fmu_byte_t rdata;
  } fmu_top_s;
endpackage

`default_nettype wire

/* File: pkg/fmu_bit_if.sv */
/*
  Carrier between the framing unit and one bit-time divider.
  Assumes the controller drives period and restart in the clock domain of the divider.
*/
`timescale 1ns/1ps
`default_nettype none

interface fmu_bit_if;
  import fmu_pkg::*;
  fmu_cnt_t period;
  logic restart;
  logic tick;
  logic mid;
  modport ctl (output period, output restart, input tick, input mid);
  modport cnt (input period, input restart, output tick, output mid);
endinterface

`default_nettype wire

/* File: design/fmu_bitclk.sv */
/*
  Bit-time divider: one-cycle tick at the end of each bit period and one
  at its middle. Assumes period is at least 3 and is held steady within a bit.
*/
`timescale 1ns/1ps
`default_nettype none

module fmu_bitclk
  import fmu_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  fmu_bit_if.cnt bi
);

  fmu_cnt_s s;
  fmu_cnt_s n;

  // Restart realigns the phase, used by the receiver on a start edge
  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.mid = 1'b0;
    if (bi.restart) begin
      n.cnt = '0;
    end else if (s.cnt >= bi.period - fmu_cnt_t'(1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + fmu_cnt_t'(1);
      n.mid = (s.cnt == (bi.period >> 1));
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bi.tick = s.tick;
  assign bi.mid = s.mid;

endmodule

`default_nettype wire

/* File: design/fmu_top.sv */
/*
  Character framing unit of a low-speed FSK modem: register port, transmit
  and receive framing, ring detector flags and the level and line driver bits.
  Assumes demodulated receive data and the ring detector level arrive
  synchronous to clock, and the host keeps its side of the register usage.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
// How it works
// - Modulation control bit 2 picks transmit level: 0 low, 1 high (3 dB up).
// - Configuration bit 6 enables the inverted line output; normal output unaffected.
// - Ring detector level reads live as event status bit 6.
// - Every ring level change, either way, sets event status bit 5.
// - Ring detection and its interrupt keep working in standby.
// - Configuration bits 0-2 set data length and parity for both directions; bit 3 sets transmit stops.
// - Unframed transmit sends all eight bits, LSB first, no framing bits.
// - Framed transmit: start space, 7/8 data LSB first, optional parity, 1/2 stops.
// - Transmit runs at 75, 150 or 1200 bps in both modes.
// - Transmit data only goes out while modulation control bit 1 is set.
// - Missing next transmit byte sets the underflow flag, status bit 1.
// - On underflow framed sends steady mark; unframed repeats the held byte.
// - Unframed receive packs eight bits, first received into D0.
// - Framed receive: start, 7/8 data from D0, optional parity, stop.
// - With parity enabled, a wrong received parity sets status bit 7.
// - Each receive byte load sets receive-ready, status bit 2.
// - Load over an unread byte also sets overflow, status bit 3.
// - Transmit rate: bit 0 high is 1200, else 75 or 150 by configuration bit 7.
// - Receive rate: bit 4 high is 1200 baud, else 75/150, while bits 1 and 5 set.
`timescale 1ns/1ps
`default_nettype none

module fmu_top
  import fmu_pkg::*;
#(
  parameter fmu_cnt_t BIT_CYC_HI = fmu_cnt_t'(`FMU_CLK_HZ / `FMU_BPS_HI),
  parameter fmu_cnt_t BIT_CYC_BELL = fmu_cnt_t'(`FMU_CLK_HZ / `FMU_BPS_BELL),
  parameter fmu_cnt_t BIT_CYC_V23 = fmu_cnt_t'(`FMU_CLK_HZ / `FMU_BPS_V23)
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic standby,
  input wire logic [`FMU_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic rx_bit,
  input wire logic ring_detect,
  output logic tx_line,
  output logic tx_level_high,
  output logic inv_out_en,
  output logic irq
);

  localparam fmu_top_s RST_S = '{
    mc: `FMU_MOD_RST,
    cfg: `FMU_CFG_RST,
    mask: `FMU_MASK_RST,
    tx_line: 1'b1,
    rx_prev: 1'b1,
    rx_st: RX_HUNT,
    default: '0
  };

  fmu_top_s s;
  fmu_top_s n;
  fmu_bit_if txi ();
  fmu_bit_if rxi ();

  logic [11:0] frame;
  logic [3:0] flen;
  logic [3:0] ndat;
  logic tx_par;
  logic tx_go;
  logic rx_go;
  logic wr_txb;
  logic rd_evt;
  logic rd_rxb;
  logic rx_load;
  fmu_byte_t rx_val;
  fmu_byte_t evt;

  // Dividers: one per direction, so each runs at its own rate
  fmu_bitclk u_txclk (
    .clock(clock),
    .rstn(rstn),
    .bi(txi.cnt)
  );

  fmu_bitclk u_rxclk (
    .clock(clock),
    .rstn(rstn),
    .bi(rxi.cnt)
  );

  // Rate select and divider control
  always_comb begin
    tx_go = s.mc[`FMU_MOD_TXEN] && !standby;
    rx_go = s.mc[`FMU_MOD_TXEN] && s.mc[`FMU_MOD_RXEN] && !standby;
    txi.restart = !tx_go;
    if (s.mc[`FMU_MOD_TXHI]) begin
      txi.period = BIT_CYC_HI;
    end else if (s.cfg[`FMU_CFG_BELL]) begin
      txi.period = BIT_CYC_BELL;
    end else begin
      txi.period = BIT_CYC_V23;
    end
    if (s.mc[`FMU_MOD_RXHI]) begin
      rxi.period = BIT_CYC_HI;
    end else if (s.cfg[`FMU_CFG_BELL]) begin
      rxi.period = BIT_CYC_BELL;
    end else begin
      rxi.period = BIT_CYC_V23;
    end
  end

  // Character image for the transmitter, bit 0 goes out first
  always_comb begin
    ndat = s.cfg[`FMU_CFG_D8] ? 4'h8 : 4'h7;
    tx_par = ^(s.txb & (s.cfg[`FMU_CFG_D8] ? 8'hff : 8'h7f)) ^ s.cfg[`FMU_CFG_ODD];
    frame = 12'hfff;
    flen = 4'h8;
    if (s.mc[`FMU_MOD_TXFR]) begin
      frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < ndat) begin
          frame[i + 1] = s.txb[i];
        end
      end
      if (s.cfg[`FMU_CFG_PEN]) begin
        frame[ndat + 4'h1] = tx_par;
      end
      flen = 4'h2 + ndat + {3'h0, s.cfg[`FMU_CFG_PEN]} + {3'h0, s.cfg[`FMU_CFG_STOP2]};
    end else begin
      frame[7:0] = s.txb;
    end
  end

  // Live event status as software sees it
  always_comb begin
    evt = 8'h00;
    evt[`FMU_EV_TXRDY] = !s.tx_full;
    evt[`FMU_EV_UDR] = s.f_udr;
    evt[`FMU_EV_RXRDY] = s.rx_ready;
    evt[`FMU_EV_OVR] = s.f_ovr;
    evt[`FMU_EV_CHG] = s.f_chg;
    evt[`FMU_EV_RING] = ring_detect;
    evt[`FMU_EV_PAR] = s.f_par;
  end

  // Whole next state: bus first, hardware sets after, so a set beats a clear
  always_comb begin
    n = s;
    wr_txb = bus_wr && (bus_addr == `FMU_OFS_TXB);
    rd_evt = bus_rd && (bus_addr == `FMU_OFS_EVT);
    rd_rxb = bus_rd && (bus_addr == `FMU_OFS_RXB);
    rx_load = 1'b0;
    rx_val = s.rx_sh;
    rxi.restart = 1'b0;
    n.rdata = 8'h00;

    // Register writes
    if (bus_wr) begin
      unique case (bus_addr)
        `FMU_OFS_MOD: n.mc = bus_wdata;
        `FMU_OFS_CFG: n.cfg = bus_wdata;
        `FMU_OFS_MASK: n.mask = bus_wdata;
        `FMU_OFS_TXB: n.txb = bus_wdata;
        default: ;
      endcase
    end
    if (wr_txb) begin
      n.tx_full = 1'b1;
    end

    // Register reads, data stand one cycle later; unmapped reads give zero
    if (bus_rd) begin
      unique case (bus_addr)
        `FMU_OFS_MOD: n.rdata = s.mc;
        `FMU_OFS_CFG: n.rdata = s.cfg;
        `FMU_OFS_EVT: n.rdata = evt;
        `FMU_OFS_MASK: n.rdata = s.mask;
        `FMU_OFS_TXB: n.rdata = s.txb;
        `FMU_OFS_RXB: n.rdata = s.rxb;
        default: n.rdata = 8'h00;
      endcase
    end
    if (rd_evt) begin
      n.f_udr = 1'b0;
      n.f_ovr = 1'b0;
      n.f_chg = 1'b0;
      n.f_par = 1'b0;
    end
    if (rd_rxb) begin
      n.rx_ready = 1'b0;
    end

    // Transmitter: one bit per tick; line rests at mark when stopped
    if (!tx_go) begin
      n.tx_left = 4'h0;
      n.tx_line = 1'b1;
    end else if (txi.tick) begin
      if (s.tx_left != 4'h0) begin
        n.tx_line = s.tx_sh[0];
        n.tx_sh = {1'b1, s.tx_sh[11:1]};
        n.tx_left = s.tx_left - 4'h1;
      end else if (s.tx_full || !s.mc[`FMU_MOD_TXFR]) begin
        // Unframed with nothing new sends the held byte again
        if (!s.tx_full) begin
          n.f_udr = 1'b1;
        end
        n.tx_line = frame[0];
        n.tx_sh = {1'b1, frame[11:1]};
        n.tx_left = flen - 4'h1;
        n.tx_full = wr_txb;
      end else begin
        n.f_udr = 1'b1;
        n.tx_line = 1'b1;
      end
    end

    // Receiver: framed hunts a falling edge, unframed samples free-running
    n.rx_prev = rx_bit;
    if (!rx_go) begin
      n.rx_st = RX_HUNT;
      n.rx_n = 4'h0;
    end else begin
      unique case (s.rx_st)
        RX_HUNT: begin
          if (!s.mc[`FMU_MOD_RXFR]) begin
            n.rx_st = RX_SYNC;
            n.rx_n = 4'h0;
          end else if (s.rx_prev && !rx_bit) begin
            rxi.restart = 1'b1; // Centres later samples in each bit
            n.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (rxi.mid) begin // A short glitch is not a start bit
            n.rx_st = rx_bit ? RX_HUNT : RX_DATA;
            n.rx_n = 4'h0;
            n.rx_par = s.cfg[`FMU_CFG_ODD];
          end
        end
        RX_DATA: begin
          if (rxi.mid) begin
            n.rx_sh = {rx_bit, s.rx_sh[7:1]};
            n.rx_par = s.rx_par ^ rx_bit;
            n.rx_n = s.rx_n + 4'h1;
            if (s.rx_n + 4'h1 == ndat) begin
              n.rx_st = s.cfg[`FMU_CFG_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rxi.mid) begin
            n.rx_par = s.rx_par ^ rx_bit; // Nonzero means mismatch
            n.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxi.mid) begin
            // Stop level is not checked; no framing flag exists
            rx_load = 1'b1;
            rx_val = s.cfg[`FMU_CFG_D8] ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
            if (s.cfg[`FMU_CFG_PEN] && s.rx_par) begin
              n.f_par = 1'b1;
            end
            n.rx_st = RX_HUNT;
          end
        end
        RX_SYNC: begin
          if (s.mc[`FMU_MOD_RXFR]) begin
            n.rx_st = RX_HUNT;
          end else if (rxi.mid) begin
            // No clock recovery here, fit for steady patterns only
            n.rx_sh = {rx_bit, s.rx_sh[7:1]};
            n.rx_n = s.rx_n + 4'h1;
            if (s.rx_n == 4'h7) begin
              rx_load = 1'b1;
              rx_val = {rx_bit, s.rx_sh[7:1]};
              n.rx_n = 4'h0;
            end
          end
        end
        default: n.rx_st = RX_HUNT;
      endcase
    end
    if (rx_load) begin
      n.rxb = rx_val;
      n.rx_ready = 1'b1;
      if (s.rx_ready && !rd_rxb) begin
        n.f_ovr = 1'b1;
      end
    end

    // Ring detector runs regardless of standby
    n.ring_prev = ring_detect;
    if (ring_detect != s.ring_prev) begin
      n.f_chg = 1'b1;
    end

    // Interrupt from masked event bits, ring level itself excluded
    n.irq = |({n.f_par, 1'b0, n.f_chg, 1'b0, n.f_ovr, n.rx_ready, n.f_udr, !n.tx_full} & s.mask);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata = s.rdata;
  assign tx_line = s.tx_line;
  assign tx_level_high = s.mc[`FMU_MOD_LVL];
  assign inv_out_en = s.cfg[`FMU_CFG_INV];
  assign irq = s.irq;

endmodule

`default_nettype wire

/* File: verification/fmu_chk.sv */
/*
  Port checker of the FSK framing unit.
  Assumes it is bound to fmu_top and sees one-cycle register strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fmu_defs.svh"

module fmu_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic standby,
  input wire logic [`FMU_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic ring_detect,
  input wire logic tx_line,
  input wire logic tx_level_high,
  input wire logic inv_out_en,
  input wire logic irq
);
  logic [7:0] mask_r;
  logic [7:0] mc_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Shadow of mask and mode, since the checker cannot see inside
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask_r <= 8'h00;
      mc_r <= 8'h00;
    end else if (bus_wr && bus_addr == `FMU_OFS_MASK) begin
      mask_r <= bus_wdata;
    end else if (bus_wr && bus_addr == `FMU_OFS_MOD) begin
      mc_r <= bus_wdata;
    end
  end

  property p_rdata_idle;
    !$past(bus_rd) |-> bus_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_ring_live;
    $past(bus_rd) && $past(bus_addr) == `FMU_OFS_EVT |-> bus_rdata[6] == $past(ring_detect);
  endproperty
  a_ring_live: assert property (p_ring_live) else $error("ring level wrong");
  property p_ring_chg;
    $changed(ring_detect) ##1 (bus_rd && bus_addr == `FMU_OFS_EVT) |=> bus_rdata[5];
  endproperty
  a_ring_chg: assert property (p_ring_chg) else $error("ring change not flagged");
  property p_evt_clear;
    (bus_rd && bus_addr == `FMU_OFS_EVT && $stable(ring_detect)) ##1 $stable(ring_detect)
      ##1 (bus_rd && bus_addr == `FMU_OFS_EVT && $stable(ring_detect)) |=> !bus_rdata[5];
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("change flag survived read");
  property p_level;
    logic v;
    (bus_wr && bus_addr == `FMU_OFS_MOD, v = bus_wdata[2]) ##1 !bus_wr |=> tx_level_high == v;
  endproperty
  a_level: assert property (p_level) else $error("level select wrong");
  property p_inv;
    logic v;
    (bus_wr && bus_addr == `FMU_OFS_CFG, v = bus_wdata[6]) ##1 !bus_wr |=> inv_out_en == v;
  endproperty
  a_inv: assert property (p_inv) else $error("inverted output enable wrong");
  property p_tx_off;
    (!mc_r[1] || standby) [*2] |-> tx_line;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("data sent while disabled");
  property p_ring_irq;
    mask_r[5] && $changed(ring_detect) |-> ##[1:3] irq;
  endproperty
  a_ring_irq: assert property (p_ring_irq) else $error("ring change raised no request");
endmodule

bind fmu_top fmu_chk chk_u (.clock(clock), .rstn(rstn), .standby(standby), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .ring_detect(ring_detect), .tx_line(tx_line), .tx_level_high(tx_level_high),
  .inv_out_en(inv_out_en), .irq(irq));

`default_nettype wire

/* File: verification/fmu_line_model.sv */
/*
  Line-side model: loops transmit data back or sends one own frame.
  Assumes own frames are launched only while the line is idle.
*/
`timescale 1ns/1ps
`default_nettype none

module fmu_line_model #(
  parameter int PER = 16
) (
  input wire logic clock,
  input wire logic tx_line,
  input wire logic loop,
  input wire logic go,
  input wire logic [11:0] frame,
  output logic rx_bit
);
  logic [11:0] sh_r = 12'hfff;
  int n_r = 0;
  int c_r = 0;
  // Own frame wins; an idle line rests at mark
  assign rx_bit = (n_r != 0) ? sh_r[0] : (loop ? tx_line : 1'b1);
  // One frame bit per PER cycles, first bit first
  always @(posedge clock) begin
    if (go) begin
      sh_r <= frame;
      n_r <= 12;
      c_r <= PER;
    end else if (n_r != 0 && c_r == 1) begin
      sh_r <= {1'b1, sh_r[11:1]};
      n_r <= n_r - 1;
      c_r <= PER;
    end else if (n_r != 0) begin
      c_r <= c_r - 1;
    end
  end
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
/*
  Self-checking bench of the FSK framing unit.
  Assumes short bit times (16, 24, 32 cycles) and the line model at 16.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fmu_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module tb_top;
  import fmu_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic standby = 1'b0;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic ring_detect = 1'b0;
  logic loop = 1'b1;
  logic go = 1'b0;
  logic [11:0] frame = 12'hfff;
  logic [7:0] bus_rdata;
  logic rx_bit, tx_line, tx_level_high, inv_out_en, irq;
  logic [15:0] expq[$];
  logic [15:0] note;
  logic [7:0] last_rd = 8'h00;
  logic rd_d = 1'b0;
  logic [7:0] d;
  int failures = 0;
  int checked = 0;
  integer seed = 32'h9345;
  int w;
  logic [7:0] cfg_tab [4] = '{8'h01, 8'h87, 8'h45, 8'h08};
  logic [7:0] mod_tab [4] = '{8'hbb, 8'haa, 8'hbf, 8'haa};
  int per_tab [4] = '{16, 24, 16, 32};

  always #2.5 clock = ~clock;

  fmu_top #(.BIT_CYC_HI(22'd16), .BIT_CYC_BELL(22'd24), .BIT_CYC_V23(22'd32)) dut_u (
    .clock(clock), .rstn(rstn), .standby(standby), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_bit(rx_bit),
    .ring_detect(ring_detect), .tx_line(tx_line), .tx_level_high(tx_level_high),
    .inv_out_en(inv_out_en), .irq(irq));

  fmu_line_model #(.PER(16)) line_u (.clock(clock), .tx_line(tx_line), .loop(loop), .go(go),
    .frame(frame), .rx_bit(rx_bit));

  // One register cycle; a read notes its expected value and compare mask
  task automatic bus_op(input logic wr, input logic [2:0] a, input logic [7:0] dat,
                        input logic [7:0] exp_v, input logic [7:0] msk);
    @(posedge clock);
    bus_wr <= wr;
    bus_rd <= !wr;
    bus_addr <= a;
    bus_wdata <= dat;
    if (!wr) expq.push_back({exp_v, msk});
    @(posedge clock);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
  endtask

  // Bounded status poll until one flag shows
  task automatic poll(input int b);
    int k;
    last_rd = 8'h00;
    for (k = 0; k < 400 && !last_rd[b]; k++) begin
      bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h00, 8'h00);
      @(posedge clock);
      #1;
    end
    `CHK(last_rd[b], 1'b1)
  endtask

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d) begin
      note = expq.pop_front();
      last_rd = bus_rdata;
      if (note[7:0] != 8'h00) `CHK(bus_rdata & note[7:0], note[15:8])
    end
    rd_d <= bus_rd;
  end

  // Whole run is some 2000 cycles; a hang ends after 20000, well inside budget
  initial begin
    #100000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    // Reset values, unmapped word, random round trip
    bus_op(1'b0, `FMU_OFS_MOD, 8'h00, 8'h00, 8'hff);
    bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h01, 8'hef);
    bus_op(1'b0, 3'h7, 8'h00, 8'h00, 8'hff);
    d = 8'($random(seed));
    bus_op(1'b1, `FMU_OFS_CFG, d, 8'h00, 8'h00);
    bus_op(1'b0, `FMU_OFS_CFG, 8'h00, d, 8'hff);
    // Looped framed characters across formats and rates
    for (int i = 0; i < 4; i++) begin
      bus_op(1'b1, `FMU_OFS_CFG, cfg_tab[i], 8'h00, 8'h00);
      bus_op(1'b1, `FMU_OFS_MOD, mod_tab[i], 8'h00, 8'h00);
      bus_op(1'b0, `FMU_OFS_RXB, 8'h00, 8'h00, 8'h00);
      `CHK(tx_level_high, mod_tab[i][2])
      `CHK(inv_out_en, cfg_tab[i][6])
      poll(`FMU_EV_TXRDY);
      d = 8'($random(seed)) | 8'h01;
      bus_op(1'b1, `FMU_OFS_TXB, d, 8'h00, 8'h00);
      for (w = 0; w < 400 && tx_line; w++) @(posedge clock);
      for (w = 0; w < 400 && !tx_line; w++) @(posedge clock);
      `CHK(w, per_tab[i])
      poll(`FMU_EV_RXRDY);
      // Looped parity is right by construction, so the flag must stay low
      `CHK(last_rd[`FMU_EV_PAR], 1'b0)
      bus_op(1'b0, `FMU_OFS_RXB, 8'h00, d & (cfg_tab[i][0] ? 8'hff : 8'h7f), 8'hff);
      repeat (4 * per_tab[i]) @(posedge clock);
      bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h02, 8'h02);
      `CHK(tx_line, 1'b1)
    end
    // Frame with wrong even parity from the line model
    loop <= 1'b0;
    bus_op(1'b1, `FMU_OFS_CFG, 8'h05, 8'h00, 8'h00);
    bus_op(1'b1, `FMU_OFS_MOD, 8'hbb, 8'h00, 8'h00);
    go <= 1'b1;
    frame <= 12'hc02;
    @(posedge clock);
    go <= 1'b0;
    poll(`FMU_EV_RXRDY);
    `CHK(last_rd[`FMU_EV_PAR], 1'b1)
    bus_op(1'b0, `FMU_OFS_RXB, 8'h00, 8'h01, 8'hff);
    // Unframed loop of a repeated zero byte, steady space only
    loop <= 1'b1;
    bus_op(1'b1, `FMU_OFS_MOD, 8'h00, 8'h00, 8'h00);
    bus_op(1'b1, `FMU_OFS_TXB, 8'h00, 8'h00, 8'h00);
    bus_op(1'b1, `FMU_OFS_MOD, 8'h33, 8'h00, 8'h00);
    repeat (480) @(posedge clock);
    bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h0e, 8'h0e);
    bus_op(1'b0, `FMU_OFS_RXB, 8'h00, 8'h00, 8'hff);
    // Ring events during standby
    bus_op(1'b1, `FMU_OFS_MASK, 8'h20, 8'h00, 8'h00);
    standby <= 1'b1;
    ring_detect <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(irq, 1'b1)
    bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h60, 8'h60);
    bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h40, 8'h60);
    ring_detect <= 1'b0;
    bus_op(1'b0, `FMU_OFS_EVT, 8'h00, 8'h20, 8'h60);
    bus_op(1'b1, `FMU_OFS_MASK, 8'h00, 8'h00, 8'h00);
    standby <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK(irq, 1'b0)
    end_of_test();
  end
endmodule

`default_nettype wire
